// ===== hw/fcc_pkg.sv
// Constants shared by the flash clock and option configuration block
package fcc_pkg;

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_CLKDIV = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_OPTIONS = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;

   // ---------------------------------------------------------------
   // Clock divider register layout
   // ---------------------------------------------------------------
   localparam int LOADED_BIT = 7;
   localparam int PRESCALE_BIT = 6;
   localparam int DIV_W = 6;
   localparam int DIV_LSB = 0;
   localparam logic [DATA_W-1:0] CLKDIV_RST = 8'h00;
   localparam int PRE_W = 3;
   localparam logic [PRE_W-1:0] PRE_LAST = 3'h7;

   // ---------------------------------------------------------------
   // Options register layout
   // ---------------------------------------------------------------
   localparam int KEY_EN_BIT = 7;
   localparam int NORED_BIT = 6;
   localparam int SEC_W = 2;
   localparam int SEC_LSB = 0;
   localparam logic [SEC_W-1:0] SEC_OPEN = 2'h2;
   localparam logic [DATA_W-1:0] OPT_IMPL_MASK = 8'hc3;
   localparam logic [DATA_W-1:0] OPT_RST = 8'h03;

   // ---------------------------------------------------------------
   // Status register layout
   // ---------------------------------------------------------------
   localparam int ST_SECURE_BIT = 0;
   localparam int ST_UNLOCKED_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_REFUSED_BIT = 3;

   // ---------------------------------------------------------------
   // Backdoor key
   // ---------------------------------------------------------------
   localparam int KEY_BYTES = 8;
   localparam int KEY_IDX_W = 3;
   localparam int KEY_CNT_W = 4;
   localparam logic [KEY_CNT_W-1:0] KEY_FULL = 4'h8;

   // ---------------------------------------------------------------
   // Program and erase timing pulse sequencer
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {PE_IDLE, PE_WAIT, PE_PULSE} fcc_pe_e;

endpackage

// ===== hw/fcc_div_if.sv
// Control and tick wires between the configuration core and the flash clock divider
`timescale 1ns/1ps
interface fcc_div_if;
   logic run;
   logic prescale;
   logic [fcc_pkg::DIV_W-1:0] divisor;
   logic tick;

   modport ctrl (output run, output prescale, output divisor, input tick);
   modport divider (input run, input prescale, input divisor, output tick);
endinterface

// ===== hw/fcc_clk_div.sv
// Flash timing clock divider producing a one-cycle enable tick
`timescale 1ns/1ps
module fcc_clk_div (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Divider control and tick
   fcc_div_if.divider div
);

   logic [fcc_pkg::PRE_W-1:0] pre_q;
   logic [fcc_pkg::PRE_W-1:0] pre_d;
   logic [fcc_pkg::DIV_W-1:0] cnt_q;
   logic [fcc_pkg::DIV_W-1:0] cnt_d;
   logic tick_q;
   logic tick_d;

   // ---------------------------------------------------------------
   // Source select and reload counter
   // ---------------------------------------------------------------
   wire pre_wrap = (pre_q == fcc_pkg::PRE_LAST);
   wire src_ce = div.prescale ? pre_wrap : 1'b1;
   wire cnt_zero = (cnt_q == {fcc_pkg::DIV_W{1'b0}});

   assign pre_d = div.run ? pre_q + {{(fcc_pkg::PRE_W-1){1'b0}}, 1'b1} : {fcc_pkg::PRE_W{1'b0}};
   // Reload at the divisor gives a period of divisor plus one
   assign cnt_d = !div.run ? div.divisor :
                  !src_ce ? cnt_q :
                  cnt_zero ? div.divisor :
                  cnt_q - {{(fcc_pkg::DIV_W-1){1'b0}}, 1'b1};
   // Enable pulse instead of a derived clock keeps one clock tree
   assign tick_d = div.run & src_ce & cnt_zero;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= {fcc_pkg::PRE_W{1'b0}};
         cnt_q <= {fcc_pkg::DIV_W{1'b0}};
         tick_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign div.tick = tick_q;

endmodule

// ===== hw/fcc_top.sv
// Flash clock divider, options, security state and backdoor key configuration
//
// Behaviour
// - Divider bit 7 is a read-only loaded flag, set by first write after reset.
// - Divider bits 6:0 are readable always and take only the first write.
// - Program and erase are refused until the loaded flag is set.
// - Prescale bit selects bus clock or bus clock divided by eight.
// - Divider divides its input by the 6-bit divisor plus one.
// - Each timing pulse lasts exactly one flash clock cycle.
// - The options byte is copied from nonvolatile storage on the first edge after reset release.
// - Options bits 5:2 read zero; bus writes to options change nothing.
// - With key enable clear, key comparison never disengages security.
// - Only secure firmware may supply key bytes; debug writes cannot unlock.
// - Eight key bytes written in order and matching unlock until next reset.
// - Options bit 6 set disables vector redirection, clear keeps it active.
// - Only security code 1:0 is unsecured; all other codes are secure.
// - While secure, unsecured sources cannot reach RAM or flash contents.
// - Working security code becomes 1:0 after key match or blank check.
// - Blocked writes are discarded and blocked reads return all zeros.
`timescale 1ns/1ps
module fcc_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [fcc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [fcc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [fcc_pkg::DATA_W-1:0] reg_rdata,
   // Nonvolatile contents
   input wire logic [fcc_pkg::DATA_W-1:0] options_nonvolatile_byte,
   input wire logic [fcc_pkg::KEY_BYTES*fcc_pkg::DATA_W-1:0] backdoor_key_bytes,
   // Backdoor key entry
   input wire logic key_access,
   input wire logic key_wr,
   input wire logic [fcc_pkg::KEY_IDX_W-1:0] key_idx,
   input wire logic [fcc_pkg::DATA_W-1:0] key_data,
   input wire logic key_src_secure,
   input wire logic blank_check_ok,
   // Program and erase timing
   input wire logic pe_req,
   output logic pe_refused,
   output logic pe_busy,
   output logic pe_pulse,
   output logic pe_done,
   output logic flash_timing_clock,
   // Secure memory gate
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_src_secure,
   input wire logic [fcc_pkg::DATA_W-1:0] mem_rdata_in,
   output logic mem_wr_en,
   output logic mem_blocked,
   output logic [fcc_pkg::DATA_W-1:0] mem_rdata,
   // Option outputs
   output logic secure,
   output logic redirect_disable,
   output logic backdoor_key_enable
);

   // ---------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------
   function automatic logic code_is_secure(input logic [fcc_pkg::SEC_W-1:0] code);
      code_is_secure = (code != fcc_pkg::SEC_OPEN);
   endfunction

   function automatic logic hits(input logic [fcc_pkg::ADDR_W-1:0] a,
                                 input logic [fcc_pkg::ADDR_W-1:0] r);
      hits = (a == r);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic loaded_q;
   logic loaded_d;
   logic [fcc_pkg::DATA_W-1:0] clkdiv_q;
   logic [fcc_pkg::DATA_W-1:0] clkdiv_d;
   logic opt_pending_q;
   logic [fcc_pkg::DATA_W-1:0] opt_q;
   logic [fcc_pkg::DATA_W-1:0] opt_d;
   logic [fcc_pkg::SEC_W-1:0] sec_q;
   logic [fcc_pkg::SEC_W-1:0] sec_d;
   logic unlocked_q;
   logic unlocked_d;
   logic refused_q;
   logic refused_d;
   logic [fcc_pkg::DATA_W-1:0] rdata_q;
   logic [fcc_pkg::DATA_W-1:0] rdata_d;
   logic [fcc_pkg::DATA_W-1:0] mem_rdata_q;
   logic [fcc_pkg::DATA_W-1:0] mem_rdata_d;
   logic key_acc_q;
   logic [fcc_pkg::KEY_CNT_W-1:0] key_cnt_q;
   logic [fcc_pkg::KEY_CNT_W-1:0] key_cnt_d;
   logic key_bad_q;
   logic key_bad_d;
   logic [fcc_pkg::KEY_BYTES*fcc_pkg::DATA_W-1:0] key_buf_q;
   logic [fcc_pkg::KEY_BYTES*fcc_pkg::DATA_W-1:0] key_buf_d;
   fcc_pkg::fcc_pe_e pe_q;
   fcc_pkg::fcc_pe_e pe_d;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire wr_clkdiv = reg_wr & hits(reg_addr, fcc_pkg::ADDR_CLKDIV);
   wire wr_status = reg_wr & hits(reg_addr, fcc_pkg::ADDR_STATUS);
   wire rd_clkdiv = hits(reg_addr, fcc_pkg::ADDR_CLKDIV);
   wire rd_options = hits(reg_addr, fcc_pkg::ADDR_OPTIONS);
   wire rd_status = hits(reg_addr, fcc_pkg::ADDR_STATUS);

   // ---------------------------------------------------------------
   // Clock divider register
   // ---------------------------------------------------------------
   // First write wins; the flag does not depend on the data
   assign loaded_d = loaded_q | wr_clkdiv;
   assign clkdiv_d = (wr_clkdiv & !loaded_q) ? reg_wdata : clkdiv_q;

   wire prescale_by_eight = clkdiv_q[fcc_pkg::PRESCALE_BIT];
   wire [fcc_pkg::DIV_W-1:0] divisor_field = clkdiv_q[fcc_pkg::DIV_LSB +: fcc_pkg::DIV_W];

   wire [fcc_pkg::DATA_W-1:0] clkdiv_view = {loaded_q, clkdiv_q[fcc_pkg::PRESCALE_BIT:0]};

   // ---------------------------------------------------------------
   // Divider instance
   // ---------------------------------------------------------------
   fcc_div_if div_bus ();

   // Divider only runs once the settings are fixed
   assign div_bus.run = loaded_q;
   assign div_bus.prescale = prescale_by_eight;
   assign div_bus.divisor = divisor_field;

   fcc_clk_div u_div (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .div(div_bus)
   );

   wire tick = div_bus.tick;

   // ---------------------------------------------------------------
   // Program and erase sequencer
   // ---------------------------------------------------------------
   wire pe_start = pe_req & loaded_q & (pe_q == fcc_pkg::PE_IDLE);
   // Requests before the divisor is loaded, or while busy, are refused
   wire pe_reject = pe_req & !pe_start;

   always_comb begin
      pe_d = pe_q;
      unique case (pe_q)
         fcc_pkg::PE_IDLE: begin
            if (pe_start) begin
               pe_d = fcc_pkg::PE_WAIT;
            end
         end
         // Align to a tick so the pulse spans one whole flash cycle
         fcc_pkg::PE_WAIT: begin
            if (tick) begin
               pe_d = fcc_pkg::PE_PULSE;
            end
         end
         fcc_pkg::PE_PULSE: begin
            if (tick) begin
               pe_d = fcc_pkg::PE_IDLE;
            end
         end
         // Unused encoding falls back to idle
         default: begin
            pe_d = fcc_pkg::PE_IDLE;
         end
      endcase
   end

   assign pe_refused = pe_reject;
   assign pe_busy = (pe_q != fcc_pkg::PE_IDLE);
   assign pe_pulse = (pe_q == fcc_pkg::PE_PULSE);
   assign pe_done = (pe_q == fcc_pkg::PE_PULSE) & tick;
   assign flash_timing_clock = tick;

   // Sticky refusal, write one to clear; a new refusal wins over the clear
   assign refused_d = pe_reject |
                      (refused_q & !(wr_status & reg_wdata[fcc_pkg::ST_REFUSED_BIT]));

   // ---------------------------------------------------------------
   // Options register
   // ---------------------------------------------------------------
   // Byte is caught on the first edge after reset release; bus writes are ignored
   assign opt_d = opt_pending_q ?
                  (options_nonvolatile_byte & fcc_pkg::OPT_IMPL_MASK) : opt_q;

   wire key_enable = opt_q[fcc_pkg::KEY_EN_BIT];

   // ---------------------------------------------------------------
   // Backdoor key entry
   // ---------------------------------------------------------------
   wire key_open = key_access & !key_acc_q;
   wire key_close = !key_access & key_acc_q;
   wire key_try = key_wr & key_access;
   // Debug-sourced writes never count toward a match
   wire key_ok_src = key_src_secure & key_enable;
   wire key_in_order = (key_cnt_q < fcc_pkg::KEY_FULL) &&
                       ({1'b0, key_idx} == key_cnt_q);

   always_comb begin
      key_cnt_d = key_cnt_q;
      key_bad_d = key_bad_q;
      key_buf_d = key_buf_q;
      if (key_open) begin
         key_cnt_d = {fcc_pkg::KEY_CNT_W{1'b0}};
         key_bad_d = 1'b0;
      end else if (key_try) begin
         if (key_ok_src & key_in_order) begin
            key_buf_d[key_idx*fcc_pkg::DATA_W +: fcc_pkg::DATA_W] = key_data;
            key_cnt_d = key_cnt_q + {{(fcc_pkg::KEY_CNT_W-1){1'b0}}, 1'b1};
         end else begin
            key_bad_d = 1'b1;
         end
      end
   end

   logic [fcc_pkg::KEY_BYTES-1:0] byte_match;
   genvar gi;
   generate
      for (gi = 0; gi < fcc_pkg::KEY_BYTES; gi++) begin : g_cmp
         assign byte_match[gi] = (key_buf_q[gi*fcc_pkg::DATA_W +: fcc_pkg::DATA_W] ==
                                  backdoor_key_bytes[gi*fcc_pkg::DATA_W +: fcc_pkg::DATA_W]);
      end
   endgenerate

   // Compared when key access closes; the enable is checked again here
   wire key_match = key_close & key_enable & !key_bad_q &
                    (key_cnt_q == fcc_pkg::KEY_FULL) & (&byte_match);

   // ---------------------------------------------------------------
   // Security state
   // ---------------------------------------------------------------
   // Opening holds until the next reset; only reset reloads the code
   assign sec_d = opt_pending_q ? options_nonvolatile_byte[fcc_pkg::SEC_LSB +: fcc_pkg::SEC_W] :
                  (key_match | blank_check_ok) ? fcc_pkg::SEC_OPEN : sec_q;
   assign unlocked_d = unlocked_q | key_match;

   wire is_secure = code_is_secure(sec_q);

   wire [fcc_pkg::DATA_W-1:0] opt_view = {opt_q[fcc_pkg::KEY_EN_BIT:fcc_pkg::NORED_BIT],
                                         {(fcc_pkg::NORED_BIT-fcc_pkg::SEC_W){1'b0}},
                                         sec_q};

   // ---------------------------------------------------------------
   // Secure memory gate
   // ---------------------------------------------------------------
   wire blocked = mem_req & is_secure & !mem_src_secure;
   assign mem_blocked = blocked;
   assign mem_wr_en = mem_req & mem_we & !blocked;
   assign mem_rdata_d = (mem_req & !mem_we & !blocked) ?
                        mem_rdata_in : {fcc_pkg::DATA_W{1'b0}};
   assign mem_rdata = mem_rdata_q;

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   wire [fcc_pkg::DATA_W-1:0] status_view = {{(fcc_pkg::DATA_W-fcc_pkg::ST_REFUSED_BIT-1){1'b0}},
                                            refused_q, pe_busy, unlocked_q, is_secure};

   // Unmapped addresses read zero; data stand only in the cycle after the strobe
   assign rdata_d = !reg_rd ? {fcc_pkg::DATA_W{1'b0}} :
                    rd_clkdiv ? clkdiv_view :
                    rd_options ? opt_view :
                    rd_status ? status_view :
                    {fcc_pkg::DATA_W{1'b0}};
   assign reg_rdata = rdata_q;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         loaded_q <= 1'b0;
         clkdiv_q <= fcc_pkg::CLKDIV_RST;
         refused_q <= 1'b0;
         pe_q <= fcc_pkg::PE_IDLE;
      end else begin
         loaded_q <= loaded_d;
         clkdiv_q <= clkdiv_d;
         refused_q <= refused_d;
         pe_q <= pe_d;
      end
   end

   // Options change only by reload; security changes by reload, key match or blank check
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         opt_pending_q <= 1'b1;
         opt_q <= fcc_pkg::OPT_RST;
         sec_q <= fcc_pkg::OPT_RST[fcc_pkg::SEC_LSB +: fcc_pkg::SEC_W];
         unlocked_q <= 1'b0;
      end else begin
         opt_pending_q <= 1'b0;
         opt_q <= opt_d;
         sec_q <= sec_d;
         unlocked_q <= unlocked_d;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         key_acc_q <= 1'b0;
         key_cnt_q <= {fcc_pkg::KEY_CNT_W{1'b0}};
         key_bad_q <= 1'b0;
         key_buf_q <= {(fcc_pkg::KEY_BYTES*fcc_pkg::DATA_W){1'b0}};
      end else begin
         key_acc_q <= key_access;
         key_cnt_q <= key_cnt_d;
         key_bad_q <= key_bad_d;
         key_buf_q <= key_buf_d;
      end
   end

   // Read data registers clear whenever no read is granted
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= {fcc_pkg::DATA_W{1'b0}};
         mem_rdata_q <= {fcc_pkg::DATA_W{1'b0}};
      end else begin
         rdata_q <= rdata_d;
         mem_rdata_q <= mem_rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Option outputs
   // ---------------------------------------------------------------
   assign secure = is_secure;
   assign redirect_disable = opt_q[fcc_pkg::NORED_BIT];
   assign backdoor_key_enable = key_enable;

endmodule

// ===== testbench/fcc_top_props.sv
// Concurrent checks on the ports of the flash clock and option configuration block
`timescale 1ns/1ps
module fcc_top_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Observed ports
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic blank_check_ok,
   input wire logic pe_req,
   input wire logic pe_refused,
   input wire logic pe_busy,
   input wire logic pe_pulse,
   input wire logic pe_done,
   input wire logic flash_timing_clock,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_src_secure,
   input wire logic [7:0] mem_rdata_in,
   input wire logic mem_wr_en,
   input wire logic mem_blocked,
   input wire logic [7:0] mem_rdata,
   input wire logic secure,
   input wire logic redirect_disable,
   input wire logic backdoor_key_enable
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   // ---------------------------------------------
   // Sequences and properties
   // ---------------------------------------------
   sequence s_wait_tick;
      pe_busy && !pe_pulse && flash_timing_clock;
   endsequence
   sequence s_end_pulse;
      (pe_pulse && flash_timing_clock) ##1 !pe_busy;
   endsequence
   property p_rdata_idle;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   property p_start_ok;
      $rose(pe_busy) |-> $past(pe_req && !pe_refused);
   endproperty
   property p_pulse_start;
      s_wait_tick |=> pe_pulse;
   endproperty
   property p_pulse_hold;
      pe_pulse && !flash_timing_clock |=> pe_pulse;
   endproperty
   property p_done;
      pe_done |-> s_end_pulse;
   endproperty
   property p_mem_gate;
      mem_req && secure && !mem_src_secure |-> mem_blocked && !mem_wr_en;
   endproperty
   property p_mem_zero;
      mem_req && !mem_we && mem_blocked |=> mem_rdata == 8'h00;
   endproperty
   property p_mem_pass;
      mem_req && !mem_we && !mem_blocked |=> mem_rdata == $past(mem_rdata_in);
   endproperty
   property p_blank;
      blank_check_ok |=> !secure;
   endproperty
   property p_backdoor_key_enable_off;
      $past(arst_n) && secure && !backdoor_key_enable && !blank_check_ok |=> secure;
   endproperty
   property p_unlock_hold;
      $past(arst_n) && !secure |=> !secure;
   endproperty
   property p_opt_fixed;
      $past(arst_n, 2) |-> $stable(redirect_disable) && $stable(backdoor_key_enable);
   endproperty

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
   a_start_ok: assert property (p_start_ok) else $error("operation began without accepted request");
   a_pulse_start: assert property (p_pulse_start) else $error("pulse missing after tick");
   a_pulse_hold: assert property (p_pulse_hold) else $error("pulse ended early");
   a_done: assert property (p_done) else $error("done out of place");
   a_mem_gate: assert property (p_mem_gate) else $error("unsecured access not blocked");
   a_mem_zero: assert property (p_mem_zero) else $error("blocked read not zero");
   a_mem_pass: assert property (p_mem_pass) else $error("allowed read data lost");
   a_blank: assert property (p_blank) else $error("blank check did not unsecure");
   a_backdoor_key_enable_off: assert property (p_backdoor_key_enable_off) else $error("unsecured with key disabled");
   a_unlock_hold: assert property (p_unlock_hold) else $error("security came back before reset");
   a_opt_fixed: assert property (p_opt_fixed) else $error("options changed after load");
endmodule

bind fcc_top fcc_top_props i_fcc_top_props (.ref_clk, .arst_n, .reg_rd, .reg_rdata, .blank_check_ok, .pe_req,
   .pe_refused, .pe_busy, .pe_pulse, .pe_done, .flash_timing_clock, .mem_req, .mem_we, .mem_src_secure,
   .mem_rdata_in, .mem_wr_en, .mem_blocked, .mem_rdata, .secure, .redirect_disable, .backdoor_key_enable);

// ===== testbench/test_flash_clock_and_option_config.sv
// Self-checking bench for the flash clock and option configuration block
`timescale 1ns/1ps
module test_flash_clock_and_option_config;
   logic ref_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, key_access = 1'h0, key_wr = 1'h0;
   logic key_src_secure = 1'h0, blank_check_ok = 1'h0, pe_req = 1'h0, mem_req = 1'h0, mem_we = 1'h0;
   logic mem_src_secure = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [2:0] key_idx = 3'h0;
   logic [7:0] reg_wdata = 8'h00, nv = 8'h00, key_data = 8'h00, mem_rdata_in = 8'h00;
   logic [63:0] key = 64'h0;
   logic [7:0] reg_rdata, mem_rdata, d, v, rdat;
   logic pe_refused, pe_busy, pe_pulse, pe_done, flash_timing_clock, mem_wr_en, mem_blocked, secure;
   logic redirect_disable, backdoor_key_enable, sx, good, src, blk;
   int seed = 32'h7858, n_mismatch = 0, compares = 0, n, i, r;

   fcc_top i_fcc_top (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .options_nonvolatile_byte(nv),
      .backdoor_key_bytes(key), .key_access(key_access), .key_wr(key_wr), .key_idx(key_idx),
      .key_data(key_data), .key_src_secure(key_src_secure), .blank_check_ok(blank_check_ok),
      .pe_req(pe_req), .pe_refused(pe_refused), .pe_busy(pe_busy), .pe_pulse(pe_pulse), .pe_done(pe_done),
      .flash_timing_clock(flash_timing_clock), .mem_req(mem_req), .mem_we(mem_we),
      .mem_src_secure(mem_src_secure), .mem_rdata_in(mem_rdata_in), .mem_wr_en(mem_wr_en),
      .mem_blocked(mem_blocked), .mem_rdata(mem_rdata), .secure(secure), .redirect_disable(redirect_disable),
      .backdoor_key_enable(backdoor_key_enable));

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ---------------------------------------------
   // Bus cycles and comparison
   // ---------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] x);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 rdat = reg_rdata;
   endtask

   // Cycles up to and including the next tick, bounded
   task automatic wait_tick;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1 n++;
      end while (!flash_timing_clock && n < 600);
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #(25 * 80000);
      n_mismatch++;
      end_sim;
   end

   // ---------------------------------------------
   // Rounds: each starts from a fresh reset
   // ---------------------------------------------
   initial begin
      for (r = 0; r < 8; r++) begin
         @(posedge ref_clk);
         v = $random(seed);
         v[1:0] = (r == 6) ? 2'h0 : r[1:0];
         v[7] = (r != 6);
         arst_n <= 1'h0;
         nv <= v;
         key <= {$random(seed), $random(seed)};
         repeat (4) @(posedge ref_clk);
         arst_n <= 1'h1;
         repeat (2) @(posedge ref_clk);
         sx = (nv[1:0] != 2'h2);
         rd(fcc_pkg::ADDR_CLKDIV);
         chk(rdat, 8'h00);
         @(posedge ref_clk);
         pe_req <= 1'h1;
         #1 chk(pe_refused, 1'h1);
         @(posedge ref_clk);
         pe_req <= 1'h0;
         rd(fcc_pkg::ADDR_STATUS);
         chk({rdat[3], rdat[0]}, {1'h1, sx});
         // Prescaled settings keep the flash clock in its legal band
         d = $random(seed);
         d[6] = (r != 3);
         d[5:0] = d[6] ? 6'h18 + {3'h0, d[2:0]} : {3'h0, d[2:0]};
         wr(fcc_pkg::ADDR_CLKDIV, d);
         wr(fcc_pkg::ADDR_CLKDIV, ~d);
         rd(fcc_pkg::ADDR_CLKDIV);
         chk(rdat, {1'h1, d[6:0]});
         rd(fcc_pkg::ADDR_OPTIONS);
         chk(rdat, nv & 8'hc3);
         wr(fcc_pkg::ADDR_OPTIONS, ~nv);
         rd(fcc_pkg::ADDR_OPTIONS);
         chk(rdat, nv & 8'hc3);
         rd(4'hf);
         chk(rdat, 8'h00);
         chk({redirect_disable, backdoor_key_enable, secure}, {nv[6], nv[7], sx});
         wait_tick;
         wait_tick;
         chk(n, (d[5:0] + 1) * (d[6] ? 8 : 1));
         // Operations only start with a legal flash clock
         if (d[6]) begin
            @(posedge ref_clk);
            pe_req <= 1'h1;
            #1 chk(pe_refused, 1'h0);
            @(posedge ref_clk);
            pe_req <= 1'h0;
            n = 0;
            i = 0;
            // A second request while busy is refused
            do begin
               @(posedge ref_clk);
               pe_req <= (i == 0);
               #1 i++;
               if (i == 1) chk(pe_refused, 1'h1);
               if (pe_pulse === 1'h1) n++;
            end while (pe_busy !== 1'h0 && i < 1200);
            chk(n, (d[5:0] + 1) * (d[6] ? 8 : 1));
            rd(fcc_pkg::ADDR_STATUS);
            chk(rdat[3:2], 2'h2);
            wr(fcc_pkg::ADDR_STATUS, 8'h08);
            rd(fcc_pkg::ADDR_STATUS);
            chk(rdat[3], 1'h0);
         end
         for (i = 0; i < 4; i++) begin
            v = $random(seed);
            blk = sx && !i[1];
            @(posedge ref_clk);
            mem_req <= 1'h1;
            mem_we <= i[0];
            mem_src_secure <= i[1];
            mem_rdata_in <= v;
            #1 chk({mem_blocked, mem_wr_en}, {blk, i[0] && !blk});
            @(posedge ref_clk);
            mem_req <= 1'h0;
            #1 if (!i[0]) chk(mem_rdata, blk ? 8'h00 : v);
         end
         good = r[2] || r >= 5;
         src = (r != 5);
         @(posedge ref_clk);
         key_access <= 1'h1;
         key_src_secure <= src;
         for (i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            key_wr <= 1'h1;
            key_idx <= i[2:0];
            key_data <= key[8*i +: 8] ^ {7'h0, !good && i == 3};
         end
         @(posedge ref_clk);
         key_wr <= 1'h0;
         key_access <= 1'h0;
         repeat (3) @(posedge ref_clk);
         #1 chk(secure, sx && !(nv[7] && src && good));
         rd(fcc_pkg::ADDR_STATUS);
         chk(rdat[1], nv[7] && src && good);
         @(posedge ref_clk);
         blank_check_ok <= 1'h1;
         @(posedge ref_clk);
         blank_check_ok <= 1'h0;
         #1 chk(secure, 1'h0);
         $display("round %0d done", r);
      end
      end_sim;
   end
endmodule
